/* src/eirg_map.svh */
`ifndef EIRG_MAP_SVH
`define EIRG_MAP_SVH
// ------------------------------------------------------------
// register offsets (byte addresses)
// ------------------------------------------------------------
`define EIRG_CTRL_OFS 12'h000
`define EIRG_PANEL_OFS 12'h004
`define EIRG_CAP1_OFS 12'h008
`define EIRG_CAP2_OFS 12'h00c
`define EIRG_TGT_OFS 12'h010
`define EIRG_LIM_OFS 12'h014
`define EIRG_TANK_OFS 12'h018
`define EIRG_STAT_OFS 12'h01c
`define EIRG_ADJ1_OFS 12'h020
`define EIRG_ADJ2_OFS 12'h024
// ------------------------------------------------------------
// control register fields
// ------------------------------------------------------------
`define EIRG_CTRL_STAT_EN 0
`define EIRG_CTRL_EXTSW_EN 1
`define EIRG_CTRL_CUT_EN 2
`define EIRG_CTRL_OPT_BOARD 3
`define EIRG_CTRL_CUT_SEL 4
`define EIRG_CTRL_GRID_EN 5
`define EIRG_CTRL_BUFFER 6
`define EIRG_CTRL_COOL_MODE 7
`define EIRG_CTRL_STOP 8
`define EIRG_CTRL_PUMPDOWN 9
`define EIRG_CTRL_TANK_SIDE 10
`define EIRG_CTRL_RST 32'h0000_0000
// ------------------------------------------------------------
// panel register fields
// ------------------------------------------------------------
`define EIRG_PANEL_ON 0
`define EIRG_PANEL_DISMISS 1
`define EIRG_PANEL_ACTIVITY 2
// ------------------------------------------------------------
// target and setting reset values
// ------------------------------------------------------------
`define EIRG_CAP_RST 8'h64
`define EIRG_ADJ_RST 8'h00
`define EIRG_ZONE_RST 8'h23
`define EIRG_BUF_RST 8'h23
`define EIRG_COOL_RST 8'h0a
`define EIRG_ZONE_MAX_RST 8'h37
`define EIRG_BUF_MAX_RST 8'h37
`define EIRG_COOL_MIN_RST 8'h05
`define EIRG_COOL_MAX_RST 8'h14
`define EIRG_TANK_RST 8'h32
`define EIRG_TANK_MAX_RST 8'h41
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define EIRG_CLK_HZ 25000000
`define EIRG_NOTICE_MIN 5
`define EIRG_NOTICE_CYC (64'(`EIRG_NOTICE_MIN) * 64'd60 * 64'(`EIRG_CLK_HZ))
`define EIRG_DEB_US 1000
`define EIRG_DEB_CYC (`EIRG_DEB_US * (`EIRG_CLK_HZ / 1000000))
`endif

/* src/eirg_pkg.sv */
package eirg_pkg;
  typedef enum logic [3:0] {
    EIRG_GRID_NORMAL = 4'b0001,
    EIRG_GRID_STOP = 4'b0010,
    EIRG_GRID_CAP1 = 4'b0100,
    EIRG_GRID_CAP2 = 4'b1000
  } eirg_grid_e;
  typedef logic [7:0] eirg_temp_t;
endpackage

/* src/eirg_gating.sv */
`timescale 1ns/100ps
`include "eirg_map.svh"
// Overview of operation
// - thermostat contacts act only when remote thermostat setting is enabled
// - heating mode uses heat contact, cooling mode uses cool contact
// - no demand from selected contact stops heat pump at once
// - valve off routes to heating, on routes to tank
// - in stop mode valve held off
// - pump-down, like stop mode, holds valve closed
// - with external switch enabled, run needs switch on and panel on
// - external switch off stops heat pump, water pump and heaters
// - panel power indicator follows only latest panel request
// - held off and dismissed, notice reappears after 5 idle minutes
// - switch back on clears notice and resumes with latest settings
// - cut input needs board and setting; control bit 4 selects mode
// - heat-source cut stops heat pump, pump and both heaters
// - heater-only cut blocks booster and backup heaters
// - cut input raises no stop notice
// - grid code 00 normal; restores previous targets after 10/11
// - grid code 01 stops heat pump and heaters
// - codes 10/11 with buffer scale buffer target by capacity percent
// - codes 10/11 without buffer scale each zone target, clamped
// - codes 10/11 scale tank target, capped at tank max
// - codes 10/11 cooling adds adjustment, clamped to min and max
module eirg_gating #(
  parameter longint NOTICE_CYC = `EIRG_NOTICE_CYC,
  parameter int DEB_CYC = `EIRG_DEB_CYC
) (
  input wire logic CLK_SYS_IN,
  input wire logic RSTN_IN,
  input wire logic HSEL_IN,
  input wire logic [11:0] HADDR_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic [2:0] HSIZE_IN,
  input wire logic [31:0] HWDATA_IN,
  input wire logic HREADY_IN,
  input wire logic TOUCH_STAT_HEAT_CONTACT_IN,
  input wire logic TOUCH_STAT_COOL_CONTACT_IN,
  input wire logic DIAL_STAT_HEAT_CONTACT_IN,
  input wire logic DIAL_STAT_COOL_CONTACT_IN,
  input wire logic EXT_SWITCH_IN,
  input wire logic COMP_CUT_IN,
  input wire logic [1:0] GRID_SIGNAL_INPUT_IN,
  input wire logic HEAT_PUMP_REQ_IN,
  input wire logic WATER_PUMP_REQ_IN,
  input wire logic BOOSTER_REQ_IN,
  input wire logic BACKUP_REQ_IN,
  output logic [31:0] HRDATA_OUT,
  output logic HREADYOUT_OUT,
  output logic HRESP_OUT,
  output logic HEAT_PUMP_RUN_OUT,
  output logic WATER_PUMP_RUN_OUT,
  output logic BOOSTER_RUN_OUT,
  output logic BACKUP_RUN_OUT,
  output logic VALVE_TANK_OUT,
  output logic POWER_LED_OUT,
  output logic STOP_NOTICE_OUT,
  output logic SYSTEM_ON_OUT
);
  localparam int NIN = 6;
  localparam int NPIN = 8;
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [31:0] ctrl_ff;
  logic panel_on_ff;
  logic [7:0] cap1_heat_ff, cap1_tank_ff, cap2_heat_ff, cap2_tank_ff;
  logic [7:0] adj1_ff, adj2_ff;
  eirg_pkg::eirg_temp_t zone1_ff, zone2_ff, buf_ff, cool_ff;
  eirg_pkg::eirg_temp_t zone_max_ff, buf_max_ff, cool_min_ff, cool_max_ff;
  eirg_pkg::eirg_temp_t tank_ff, tank_max_ff;
  eirg_pkg::eirg_temp_t z1_eff_ff, z2_eff_ff, buf_eff_ff, tank_eff_ff, cool_eff_ff;
  logic [11:0] addr_ff;
  logic wr_ff;
  logic panel_act;
  logic dismiss_pulse;
  // ------------------------------------------------------------
  // input synchronisers and qualifiers
  // ------------------------------------------------------------
  logic [NPIN-1:0] raw_in;
  logic [NPIN-1:0] sync1_ff, sync2_ff;
  logic [NIN-1:0] deb_in, stable_ff;
  // every pin synchronised alone, contacts merged only after the second flop
  assign raw_in = {GRID_SIGNAL_INPUT_IN, COMP_CUT_IN, EXT_SWITCH_IN, DIAL_STAT_COOL_CONTACT_IN,
                   TOUCH_STAT_COOL_CONTACT_IN, DIAL_STAT_HEAT_CONTACT_IN, TOUCH_STAT_HEAT_CONTACT_IN};
  assign deb_in = {sync2_ff[7:4], sync2_ff[3] | sync2_ff[2], sync2_ff[1] | sync2_ff[0]};
  always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      sync1_ff <= '0;
      sync2_ff <= '0;
    end else begin
      sync1_ff <= raw_in;
      sync2_ff <= sync1_ff;
    end
  end
  genvar gi;
  generate
    for (gi = 0; gi < NIN; gi++) begin : g_deb
      logic [31:0] cnt_ff;
      // a change must hold for DEB_CYC cycles before it counts
      always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
        if (!RSTN_IN) begin
          cnt_ff <= '0;
          stable_ff[gi] <= 1'b0;
        end else if (deb_in[gi] == stable_ff[gi]) begin
          cnt_ff <= '0;
        end else if (cnt_ff >= 32'(DEB_CYC - 1)) begin
          cnt_ff <= '0;
          stable_ff[gi] <= deb_in[gi];
        end else begin
          cnt_ff <= cnt_ff + 32'h0000_0001;
        end
      end
    end
  endgenerate
  logic heat_c, cool_c, ext_sw, cut_sw;
  logic [1:0] grid;
  assign heat_c = stable_ff[0];
  assign cool_c = stable_ff[1];
  assign ext_sw = stable_ff[2];
  assign cut_sw = stable_ff[3];
  assign grid = stable_ff[5:4];
  // ------------------------------------------------------------
  // run gating
  // ------------------------------------------------------------
  logic cool_mode, stat_demand, ext_ok, cut_en, src_cut, htr_cut, grid_stop;
  assign cool_mode = ctrl_ff[`EIRG_CTRL_COOL_MODE];
  assign stat_demand = !ctrl_ff[`EIRG_CTRL_STAT_EN] || (cool_mode ? cool_c : heat_c);
  assign ext_ok = !ctrl_ff[`EIRG_CTRL_EXTSW_EN] || ext_sw;
  assign cut_en = ctrl_ff[`EIRG_CTRL_CUT_EN] && ctrl_ff[`EIRG_CTRL_OPT_BOARD];
  assign src_cut = cut_en && !ctrl_ff[`EIRG_CTRL_CUT_SEL] && !cut_sw;
  assign htr_cut = cut_en && ctrl_ff[`EIRG_CTRL_CUT_SEL] && !cut_sw;
  assign grid_stop = ctrl_ff[`EIRG_CTRL_GRID_EN] && grid == 2'b01;
  logic sys_on;
  assign sys_on = panel_on_ff && ext_ok && !ctrl_ff[`EIRG_CTRL_STOP];
  always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      HEAT_PUMP_RUN_OUT <= 1'b0;
      WATER_PUMP_RUN_OUT <= 1'b0;
      BOOSTER_RUN_OUT <= 1'b0;
      BACKUP_RUN_OUT <= 1'b0;
      SYSTEM_ON_OUT <= 1'b0;
      POWER_LED_OUT <= 1'b0;
      VALVE_TANK_OUT <= 1'b0;
    end else begin
      HEAT_PUMP_RUN_OUT <= sys_on && HEAT_PUMP_REQ_IN && stat_demand && !src_cut && !grid_stop;
      WATER_PUMP_RUN_OUT <= sys_on && WATER_PUMP_REQ_IN && !src_cut;
      BOOSTER_RUN_OUT <= sys_on && BOOSTER_REQ_IN && !src_cut && !htr_cut && !grid_stop;
      BACKUP_RUN_OUT <= sys_on && BACKUP_REQ_IN && !src_cut && !htr_cut && !grid_stop;
      SYSTEM_ON_OUT <= sys_on;
      POWER_LED_OUT <= panel_on_ff;
      if (ctrl_ff[`EIRG_CTRL_STOP] || ctrl_ff[`EIRG_CTRL_PUMPDOWN]) begin
        VALVE_TANK_OUT <= 1'b0;
      end else begin
        VALVE_TANK_OUT <= ctrl_ff[`EIRG_CTRL_TANK_SIDE];
      end
    end
  end
  // ------------------------------------------------------------
  // stop notice (cut input never raises it)
  // ------------------------------------------------------------
  logic held_off, dismissed_ff;
  // five minutes at the full clock needs 33 bits
  logic [32:0] idle_ff;
  // a dismissed notice waits for a quiet panel before it comes back
  assign held_off = ctrl_ff[`EIRG_CTRL_EXTSW_EN] && !ext_sw;
  always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      STOP_NOTICE_OUT <= 1'b0;
      dismissed_ff <= 1'b0;
      idle_ff <= '0;
    end else if (!held_off) begin
      STOP_NOTICE_OUT <= 1'b0;
      dismissed_ff <= 1'b0;
      idle_ff <= '0;
    end else if (dismiss_pulse) begin
      STOP_NOTICE_OUT <= 1'b0;
      dismissed_ff <= 1'b1;
      idle_ff <= '0;
    end else if (dismissed_ff) begin
      if (panel_act) begin
        idle_ff <= '0;
      end else if (idle_ff >= 33'(NOTICE_CYC - 1)) begin
        STOP_NOTICE_OUT <= 1'b1;
        dismissed_ff <= 1'b0;
        idle_ff <= '0;
      end else begin
        idle_ff <= idle_ff + 33'h0_0000_0001;
      end
    end else begin
      STOP_NOTICE_OUT <= 1'b1;
    end
  end
  // ------------------------------------------------------------
  // grid signal target scaling
  // ------------------------------------------------------------
  // base targets stay untouched, so code 00 restores them
  eirg_pkg::eirg_grid_e grid_st;
  always_comb begin
    if (!ctrl_ff[`EIRG_CTRL_GRID_EN]) begin
      grid_st = eirg_pkg::EIRG_GRID_NORMAL;
    end else begin
      case (grid)
        2'b01: grid_st = eirg_pkg::EIRG_GRID_STOP;
        2'b10: grid_st = eirg_pkg::EIRG_GRID_CAP1;
        2'b11: grid_st = eirg_pkg::EIRG_GRID_CAP2;
        default: grid_st = eirg_pkg::EIRG_GRID_NORMAL;
      endcase
    end
  end
  function automatic logic [7:0] scale(input logic [7:0] t, input logic [7:0] pct,
                                       input logic [7:0] lo, input logic [7:0] hi);
    logic [15:0] p;
    p = (16'(t) * 16'(pct)) / 16'd100;
    if (p > 16'(hi)) begin
      scale = hi;
    end else if (p < 16'(lo)) begin
      scale = lo;
    end else begin
      scale = p[7:0];
    end
  endfunction
  logic cap_act;
  logic [7:0] hpct, tpct;
  logic signed [8:0] adj;
  // one spare bit keeps the cooling sum from wrapping
  logic signed [9:0] csum;
  assign cap_act = grid_st == eirg_pkg::EIRG_GRID_CAP1 || grid_st == eirg_pkg::EIRG_GRID_CAP2;
  assign hpct = grid_st == eirg_pkg::EIRG_GRID_CAP2 ? cap2_heat_ff : cap1_heat_ff;
  assign tpct = grid_st == eirg_pkg::EIRG_GRID_CAP2 ? cap2_tank_ff : cap1_tank_ff;
  assign adj = 9'(signed'(grid_st == eirg_pkg::EIRG_GRID_CAP2 ? adj2_ff : adj1_ff));
  assign csum = 10'(signed'({1'b0, cool_ff})) + 10'(adj);
  always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      z1_eff_ff <= '0;
      z2_eff_ff <= '0;
      buf_eff_ff <= '0;
      tank_eff_ff <= '0;
      cool_eff_ff <= '0;
    end else if (!cap_act) begin
      z1_eff_ff <= zone1_ff;
      z2_eff_ff <= zone2_ff;
      buf_eff_ff <= buf_ff;
      tank_eff_ff <= tank_ff;
      cool_eff_ff <= cool_ff;
    end else begin
      if (ctrl_ff[`EIRG_CTRL_BUFFER]) begin
        buf_eff_ff <= scale(buf_ff, hpct, 8'h00, buf_max_ff);
        z1_eff_ff <= zone1_ff;
        z2_eff_ff <= zone2_ff;
      end else begin
        buf_eff_ff <= buf_ff;
        z1_eff_ff <= scale(zone1_ff, hpct, 8'h00, zone_max_ff);
        z2_eff_ff <= scale(zone2_ff, hpct, 8'h00, zone_max_ff);
      end
      tank_eff_ff <= scale(tank_ff, tpct, 8'h00, tank_max_ff);
      if (!cool_mode) begin
        cool_eff_ff <= cool_ff;
      end else if (csum > signed'({1'b0, cool_max_ff})) begin
        cool_eff_ff <= cool_max_ff;
      end else if (csum < signed'({1'b0, cool_min_ff})) begin
        cool_eff_ff <= cool_min_ff;
      end else begin
        cool_eff_ff <= csum[7:0];
      end
    end
  end
  // ------------------------------------------------------------
  // ahb-lite slave, zero wait state
  // ------------------------------------------------------------
  // hreadyout and hresp are fixed: no wait states, always okay
  logic acc;
  assign acc = HSEL_IN && HREADY_IN && HTRANS_IN[1];
  assign panel_act = wr_ff && addr_ff == `EIRG_PANEL_OFS;
  assign dismiss_pulse = panel_act && HWDATA_IN[`EIRG_PANEL_DISMISS];
  always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      addr_ff <= '0;
      wr_ff <= 1'b0;
      HREADYOUT_OUT <= 1'b1;
      HRESP_OUT <= 1'b0;
    end else begin
      addr_ff <= HADDR_IN;
      wr_ff <= acc && HWRITE_IN;
    end
  end
  // ------------------------------------------------------------
  // read data
  // ------------------------------------------------------------
  always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      HRDATA_OUT <= '0;
    end else if (acc && !HWRITE_IN) begin
      if (HADDR_IN == `EIRG_CTRL_OFS) begin
        HRDATA_OUT <= ctrl_ff;
      end else if (HADDR_IN == `EIRG_PANEL_OFS) begin
        HRDATA_OUT <= {31'h0, panel_on_ff};
      end else if (HADDR_IN == `EIRG_CAP1_OFS) begin
        HRDATA_OUT <= {16'h0, cap1_tank_ff, cap1_heat_ff};
      end else if (HADDR_IN == `EIRG_CAP2_OFS) begin
        HRDATA_OUT <= {16'h0, cap2_tank_ff, cap2_heat_ff};
      end else if (HADDR_IN == `EIRG_TGT_OFS) begin
        HRDATA_OUT <= {cool_ff, buf_ff, zone2_ff, zone1_ff};
      end else if (HADDR_IN == `EIRG_LIM_OFS) begin
        HRDATA_OUT <= {cool_max_ff, cool_min_ff, buf_max_ff, zone_max_ff};
      end else if (HADDR_IN == `EIRG_TANK_OFS) begin
        HRDATA_OUT <= {16'h0, tank_max_ff, tank_ff};
      end else if (HADDR_IN == `EIRG_STAT_OFS) begin
        HRDATA_OUT <= {tank_eff_ff, cool_eff_ff, buf_eff_ff, 2'b00, stable_ff};
      end else if (HADDR_IN == `EIRG_ADJ1_OFS) begin
        HRDATA_OUT <= {z2_eff_ff, z1_eff_ff, adj2_ff, adj1_ff};
      end else begin
        HRDATA_OUT <= '0;
      end
    end
  end
  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------
  always_ff @(posedge CLK_SYS_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      ctrl_ff <= `EIRG_CTRL_RST;
      panel_on_ff <= 1'b0;
      cap1_heat_ff <= `EIRG_CAP_RST;
      cap1_tank_ff <= `EIRG_CAP_RST;
      cap2_heat_ff <= `EIRG_CAP_RST;
      cap2_tank_ff <= `EIRG_CAP_RST;
      adj1_ff <= `EIRG_ADJ_RST;
      adj2_ff <= `EIRG_ADJ_RST;
      zone1_ff <= `EIRG_ZONE_RST;
      zone2_ff <= `EIRG_ZONE_RST;
      buf_ff <= `EIRG_BUF_RST;
      cool_ff <= `EIRG_COOL_RST;
      zone_max_ff <= `EIRG_ZONE_MAX_RST;
      buf_max_ff <= `EIRG_BUF_MAX_RST;
      cool_min_ff <= `EIRG_COOL_MIN_RST;
      cool_max_ff <= `EIRG_COOL_MAX_RST;
      tank_ff <= `EIRG_TANK_RST;
      tank_max_ff <= `EIRG_TANK_MAX_RST;
    end else if (wr_ff) begin
      if (addr_ff == `EIRG_CTRL_OFS) begin
        ctrl_ff <= {21'h0, HWDATA_IN[10:0]};
      end else if (addr_ff == `EIRG_PANEL_OFS) begin
        panel_on_ff <= HWDATA_IN[`EIRG_PANEL_ON];
      end else if (addr_ff == `EIRG_CAP1_OFS) begin
        cap1_heat_ff <= HWDATA_IN[7:0];
        cap1_tank_ff <= HWDATA_IN[15:8];
      end else if (addr_ff == `EIRG_CAP2_OFS) begin
        cap2_heat_ff <= HWDATA_IN[7:0];
        cap2_tank_ff <= HWDATA_IN[15:8];
      end else if (addr_ff == `EIRG_TGT_OFS) begin
        zone1_ff <= HWDATA_IN[7:0];
        zone2_ff <= HWDATA_IN[15:8];
        buf_ff <= HWDATA_IN[23:16];
        cool_ff <= HWDATA_IN[31:24];
      end else if (addr_ff == `EIRG_LIM_OFS) begin
        zone_max_ff <= HWDATA_IN[7:0];
        buf_max_ff <= HWDATA_IN[15:8];
        cool_min_ff <= HWDATA_IN[23:16];
        cool_max_ff <= HWDATA_IN[31:24];
      end else if (addr_ff == `EIRG_TANK_OFS) begin
        tank_ff <= HWDATA_IN[7:0];
        tank_max_ff <= HWDATA_IN[15:8];
      end else if (addr_ff == `EIRG_ADJ1_OFS) begin
        adj1_ff <= HWDATA_IN[7:0];
        adj2_ff <= HWDATA_IN[15:8];
      end
    end
  end
endmodule

/* tb/eirg_contacts.sv */
`timescale 1ns/100ps
module eirg_contacts (
  input wire logic [7:0] set_in,
  input wire logic [7:0] act_in,
  output logic heat_out,
  output logic cool_out
);
  // contact closes on demand, open otherwise
  assign heat_out = set_in > act_in;
  assign cool_out = act_in > set_in;
endmodule

/* tb/eirg_gating_properties.sv */
`timescale 1ns/100ps
module eirg_gating_properties (
  input wire logic CLK_SYS_IN,
  input wire logic RSTN_IN,
  input wire logic HSEL_IN,
  input wire logic [1:0] HTRANS_IN,
  input wire logic HWRITE_IN,
  input wire logic HREADY_IN,
  input wire logic HEAT_PUMP_REQ_IN,
  input wire logic WATER_PUMP_REQ_IN,
  input wire logic BOOSTER_REQ_IN,
  input wire logic BACKUP_REQ_IN,
  input wire logic [31:0] HRDATA_OUT,
  input wire logic HREADYOUT_OUT,
  input wire logic HRESP_OUT,
  input wire logic HEAT_PUMP_RUN_OUT,
  input wire logic WATER_PUMP_RUN_OUT,
  input wire logic BOOSTER_RUN_OUT,
  input wire logic BACKUP_RUN_OUT,
  input wire logic POWER_LED_OUT,
  input wire logic STOP_NOTICE_OUT,
  input wire logic SYSTEM_ON_OUT
);
  // ------------------------------------------------
  // port relations
  // ------------------------------------------------
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (!RSTN_IN);
  wire logic rd_taken = HSEL_IN && HREADY_IN && HTRANS_IN[1] && !HWRITE_IN;
  bus_okay_a: assert property (HREADYOUT_OUT && !HRESP_OUT)
    else $error("bus slave not ready or not okay");
  rdata_hold_a: assert property (!$past(rd_taken) |-> $stable(HRDATA_OUT))
    else $error("read data moved without a read");
  hp_gate_a: assert property (!HEAT_PUMP_REQ_IN |=> !HEAT_PUMP_RUN_OUT)
    else $error("heat pump runs without request");
  pump_gate_a: assert property (!WATER_PUMP_REQ_IN [*2] |-> !WATER_PUMP_RUN_OUT)
    else $error("water pump runs without request");
  booster_gate_a: assert property ($rose(BOOSTER_RUN_OUT) |-> $past(BOOSTER_REQ_IN))
    else $error("booster started without request");
  backup_gate_a: assert property (BACKUP_RUN_OUT && !BACKUP_REQ_IN |=> !BACKUP_RUN_OUT)
    else $error("backup heater kept after request drop");
  notice_off_a: assert property (STOP_NOTICE_OUT |-> !SYSTEM_ON_OUT)
    else $error("stop notice while system on");
  led_follow_a: assert property (SYSTEM_ON_OUT |-> POWER_LED_OUT)
    else $error("system on with panel off");
  hp_system_a: assert property (!SYSTEM_ON_OUT [*2] |-> !HEAT_PUMP_RUN_OUT)
    else $error("heat pump runs with system off");
  cover property ($rose(STOP_NOTICE_OUT));
  cover property ($fell(SYSTEM_ON_OUT));
  cover property ($rose(BACKUP_RUN_OUT));
endmodule
bind eirg_gating eirg_gating_properties chk_u (.CLK_SYS_IN(CLK_SYS_IN), .RSTN_IN(RSTN_IN),
  .HSEL_IN(HSEL_IN), .HTRANS_IN(HTRANS_IN), .HWRITE_IN(HWRITE_IN), .HREADY_IN(HREADY_IN),
  .HEAT_PUMP_REQ_IN(HEAT_PUMP_REQ_IN), .WATER_PUMP_REQ_IN(WATER_PUMP_REQ_IN),
  .BOOSTER_REQ_IN(BOOSTER_REQ_IN), .BACKUP_REQ_IN(BACKUP_REQ_IN), .HRDATA_OUT(HRDATA_OUT),
  .HREADYOUT_OUT(HREADYOUT_OUT), .HRESP_OUT(HRESP_OUT), .HEAT_PUMP_RUN_OUT(HEAT_PUMP_RUN_OUT),
  .WATER_PUMP_RUN_OUT(WATER_PUMP_RUN_OUT), .BOOSTER_RUN_OUT(BOOSTER_RUN_OUT),
  .BACKUP_RUN_OUT(BACKUP_RUN_OUT), .POWER_LED_OUT(POWER_LED_OUT),
  .STOP_NOTICE_OUT(STOP_NOTICE_OUT), .SYSTEM_ON_OUT(SYSTEM_ON_OUT));

/* tb/testbench.sv */
`timescale 1ns/100ps
`include "eirg_map.svh"
module testbench;
  // ------------------------------------------------
  // bench, contacts and design
  // ------------------------------------------------
  localparam int DEB = 4;
  localparam int NTC = 200;
  logic clk = 1'b0, rstn = 1'b0, hsel = 1'b0, hwrite = 1'b0, ext = 1'b1, cut = 1'b1;
  logic [11:0] haddr = 12'h000;
  logic [1:0] htrans = 2'h0, grid = 2'h0;
  logic [31:0] hwdata = 32'h0, rd;
  logic [3:0] req = 4'h0;
  logic [7:0] set_t = 8'h14, dset_t = 8'h14, act_t = 8'h14;
  wire logic th_h, th_c, td_h, td_c, hrdy;
  wire logic [31:0] hrdata;
  wire logic [7:0] outs;
  int num_errors = 0;
  int total_checks = 0;
  eirg_contacts touch_u (.set_in(set_t), .act_in(act_t), .heat_out(th_h), .cool_out(th_c));
  eirg_contacts dial_u (.set_in(dset_t), .act_in(act_t), .heat_out(td_h), .cool_out(td_c));
  eirg_gating #(.NOTICE_CYC(NTC), .DEB_CYC(DEB)) dut_u (.CLK_SYS_IN(clk), .RSTN_IN(rstn),
    .HSEL_IN(hsel), .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(3'h2),
    .HWDATA_IN(hwdata), .HREADY_IN(hrdy), .TOUCH_STAT_HEAT_CONTACT_IN(th_h),
    .TOUCH_STAT_COOL_CONTACT_IN(th_c), .DIAL_STAT_HEAT_CONTACT_IN(td_h),
    .DIAL_STAT_COOL_CONTACT_IN(td_c), .EXT_SWITCH_IN(ext), .COMP_CUT_IN(cut),
    .GRID_SIGNAL_INPUT_IN(grid), .HEAT_PUMP_REQ_IN(req[3]), .WATER_PUMP_REQ_IN(req[2]),
    .BOOSTER_REQ_IN(req[1]), .BACKUP_REQ_IN(req[0]), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hrdy),
    .HRESP_OUT(), .HEAT_PUMP_RUN_OUT(outs[7]), .WATER_PUMP_RUN_OUT(outs[6]),
    .BOOSTER_RUN_OUT(outs[5]), .BACKUP_RUN_OUT(outs[4]), .VALVE_TANK_OUT(outs[3]),
    .POWER_LED_OUT(outs[2]), .STOP_NOTICE_OUT(outs[1]), .SYSTEM_ON_OUT(outs[0]));
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task settle;
    repeat (DEB + 8) @(posedge clk);
  endtask
  // outs bits: hp, pump, booster, backup, valve, led, notice, system
  task ck(input logic [7:0] m, input logic [7:0] e);
    settle();
    #1 chk({24'h0, outs & m}, {24'h0, e});
    @(posedge clk);
  endtask
  task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1);
    rd = hrdata;
  endtask
  task ctl(input logic [31:0] d);
    xfer(1'b1, `EIRG_CTRL_OFS, d);
  endtask
  task pnl(input logic [31:0] d);
    xfer(1'b1, `EIRG_PANEL_OFS, d);
  endtask
  task rdm(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
    settle();
    xfer(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask
  task sw(input logic e, input logic c, input logic [1:0] g);
    ext <= e;
    cut <= c;
    grid <= g;
  endtask
  task t_stat;
    pnl(32'h1);
    ctl(32'h1);
    req <= 4'h8;
    set_t <= 8'h1e;
    ck(8'h80, 8'h80);
    set_t <= 8'h0a;
    ck(8'h80, 8'h00);
    set_t <= 8'h14;
    ctl(32'h81);
    dset_t <= 8'h0a;
    ck(8'h80, 8'h80);
    dset_t <= 8'h1e;
    ck(8'h80, 8'h00);
    ctl(32'h80);
    ck(8'h80, 8'h80);
    dset_t <= 8'h14;
  endtask
  task t_valve;
    ctl(32'h400);
    ck(8'h08, 8'h08);
    ctl(32'h500);
    ck(8'h08, 8'h00);
    ctl(32'h600);
    ck(8'h08, 8'h00);
  endtask
  task t_ext;
    req <= 4'hf;
    ctl(32'h2);
    ck(8'hf7, 8'hf5);
    pnl(32'h0);
    ck(8'hf7, 8'h00);
    pnl(32'h1);
    sw(1'b0, 1'b1, 2'h0);
    ck(8'hf7, 8'h06);
    pnl(32'h3);
    ck(8'h06, 8'h04);
    repeat (NTC - 30) @(posedge clk);
    ck(8'h02, 8'h00);
    repeat (20) @(posedge clk);
    ck(8'h02, 8'h02);
    pnl(32'h0);
    ck(8'h04, 8'h00);
    pnl(32'h1);
    sw(1'b1, 1'b1, 2'h0);
    ck(8'hf7, 8'hf5);
  endtask
  task t_cut;
    ctl(32'h0e);
    sw(1'b1, 1'b0, 2'h0);
    ck(8'hf6, 8'h04);
    ctl(32'h1e);
    ck(8'hf6, 8'hc4);
    ctl(32'h06);
    ck(8'hf6, 8'hf4);
    ctl(32'h0a);
    ck(8'hf6, 8'hf4);
    sw(1'b1, 1'b1, 2'h0);
  endtask
  task t_grid;
    rdm(12'h040, 32'hffff_ffff, 32'h0);
    xfer(1'b1, `EIRG_CAP1_OFS, 32'h0000_7896);
    xfer(1'b1, `EIRG_CAP2_OFS, 32'h0000_9632);
    xfer(1'b1, `EIRG_ADJ1_OFS, 32'h0000_f1fe);
    ctl(32'h20);
    sw(1'b1, 1'b1, 2'h1);
    ck(8'hb0, 8'h00);
    sw(1'b1, 1'b1, 2'h2);
    rdm(`EIRG_ADJ1_OFS, 32'hffff_0000, 32'h3434_0000);
    rdm(`EIRG_STAT_OFS, 32'hff00_ff00, 32'h3c00_2300);
    sw(1'b1, 1'b1, 2'h3);
    rdm(`EIRG_ADJ1_OFS, 32'hffff_0000, 32'h1111_0000);
    rdm(`EIRG_STAT_OFS, 32'hff00_0000, 32'h4100_0000);
    ctl(32'h60);
    rdm(`EIRG_ADJ1_OFS, 32'hffff_0000, 32'h2323_0000);
    rdm(`EIRG_STAT_OFS, 32'h0000_ff00, 32'h0000_1100);
    ctl(32'ha0);
    rdm(`EIRG_STAT_OFS, 32'h00ff_0000, 32'h0005_0000);
    sw(1'b1, 1'b1, 2'h2);
    rdm(`EIRG_STAT_OFS, 32'h00ff_0000, 32'h0008_0000);
    ctl(32'h20);
    sw(1'b1, 1'b1, 2'h0);
    rdm(`EIRG_STAT_OFS, 32'hff00_0000, 32'h3200_0000);
    rdm(`EIRG_ADJ1_OFS, 32'hffff_0000, 32'h2323_0000);
  endtask
  task t_deb;
    logic lo;
    lo = 1'b0;
    ctl(32'h2);
    ext <= 1'b0;
    repeat (2) @(posedge clk);
    ext <= 1'b1;
    repeat (DEB + 8) begin
      @(posedge clk);
      #1 lo = lo | !outs[0];
    end
    chk({31'h0, lo}, 32'h0);
    @(posedge clk);
    req <= 4'h0;
    ck(8'hf0, 8'h00);
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial forever #20 clk = ~clk;
  initial begin
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    t_stat();
    t_valve();
    t_ext();
    t_cut();
    t_grid();
    t_deb();
    print_verdict();
  end
  initial begin
    repeat (8000) @(posedge clk);
    num_errors++;
    print_verdict();
  end
endmodule
